//--- vm_exit_seq.sv
/*
  Late entry-failure, machine-check and exit sequencer with an AXI4-Lite
  register slave. Assumes the core shares aclk, pulses its events for one
  cycle and answers each requested step with step_done.
*/
// Design decisions made here: the address map and the AXI4-Lite slave port.
module vm_exit_seq (
  input  wire logic                   aclk,         // Core clock
  input  wire logic                   aresetn,      // Sync reset, low
  input  wire logic                   ce,           // Clock enable
  input  wire vm_exit_pkg::core_ev_type ev,         // Core events
  input  wire logic                   step_done,    // Step finished
  output vm_exit_pkg::step_type       step_req,     // Step wanted
  output logic                        nmi_block_out,// Restored blocking
  output logic                        mc_deliver,   // Deliver exception
  output logic                        shutdown,     // Shutdown state
  output logic                        txt_shutdown, // Trusted shutdown
  output logic [15:0]                 txt_code,     // Its error code
  output logic                        branch_log_off,// Trace inhibit
  input  wire logic [7:0]             awaddr,       // Write address
  input  wire logic                   awvalid,      // Address valid
  output logic                        awready,      // Address ready
  input  wire logic [31:0]            wdata,        // Write data
  input  wire logic [3:0]             wstrb,        // Byte enables
  input  wire logic                   wvalid,       // Data valid
  output logic                        wready,       // Data ready
  output logic [1:0]                  bresp,        // Write response
  output logic                        bvalid,       // Response valid
  input  wire logic                   bready,       // Response ready
  input  wire logic [7:0]             araddr,       // Read address
  input  wire logic                   arvalid,      // Address valid
  output logic                        arready,      // Address ready
  output logic [31:0]                 rdata,        // Read data
  output logic [1:0]                  rresp,        // Read response
  output logic                        rvalid,       // Read valid
  input  wire logic                   rready        // Read ready
);
  import vm_exit_pkg::*;

  seq_state_type     state_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0]       cause_reg;
  logic [31:0]       qual_reg;
  logic              inject_reg;
  logic              nmi_saved_reg;
  logic              safer_reg;
  logic              smm_exit_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              mc_reg;
  logic              shut_reg;
  logic              txt_reg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Guest-check kind to qualification; 1 is never produced
  function automatic logic [31:0] guest_qual(input logic [1:0] kind);
    logic [31:0] q;
    q = QUAL_ZERO;
    unique case (kind)
      KIND_PDPTE: q = QUAL_PDPTE;
      KIND_NMI:   q = QUAL_NMI;
      KIND_LINK:  q = QUAL_LINK;
      KIND_OTHER: q = QUAL_ZERO;
    endcase
    return q;
  endfunction

  // Entry-failure cause word: bit 31 set, 30:16 clear
  function automatic logic [31:0] fail_cause(input logic [15:0] basic);
    return {1'b1, CAUSE_MID_ZERO, basic};
  endfunction

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return a == CTRL_OFS || a == CAUSE_OFS || a == QUAL_OFS ||
           a == STATUS_OFS || a == INJECT_OFS;
  endfunction

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  logic in_entry;
  logic mc_normal;
  logic mc_fail;
  logic guest_fail;
  logic msr_fail;
  logic smm_req;
  logic pdpte_need;

  assign in_entry   = state_reg == ST_ENTRY;
  // Machine check loses the normal path once guest state is loaded
  assign mc_normal  = in_entry && ev.mchk && !ev.guest_loaded;
  assign mc_fail    = in_entry && ev.mchk && ev.guest_loaded;
  // Only one cause is reported; machine check outranks checks
  assign guest_fail = in_entry && !ev.mchk && ev.check_fail;
  assign msr_fail   = in_entry && !ev.mchk && !ev.check_fail && ev.msr_fail;
  // Management exit from guest or from root operation
  assign smm_req    = (state_reg == ST_GUEST || state_reg == ST_IDLE) &&
                      (ev.system_mgmt_interrupt || ev.hcall);
  assign pdpte_need = ctrl_reg[CTRL_PAE] && ctrl_reg[CTRL_PG] &&
                      !ctrl_reg[CTRL_LMA];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Steps wait on step_done; record steps take one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (smm_req) begin
            state_reg <= X_REC;
          end else if (ev.entry_start) begin
            state_reg <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          if (mc_normal) begin
            // Exception or shutdown; trusted shutdown also halts
            state_reg <= ctrl_reg[CTRL_MCE] ? ST_IDLE : ST_HALT;
          end else if (mc_fail || guest_fail || msr_fail) begin
            state_reg <= F_HOST;
          end else if (ev.entry_ok) begin
            state_reg <= ST_GUEST;
          end
        end
        ST_GUEST: begin
          if (ev.exit_req || smm_req) begin
            state_reg <= X_REC;
          end
        end
        // Ordinary exit order: record, save, store, host, monitor, load
        X_REC:   state_reg <= X_SAVE;
        X_SAVE: begin
          if (step_done) begin
            state_reg <= ctrl_reg[CTRL_STORE] ? X_STORE : X_HOST;
          end
        end
        X_STORE: begin
          if (step_done) begin
            state_reg <= X_HOST;
          end
        end
        X_HOST: begin
          // Dual-monitor management exits skip the host load
          if (smm_exit_reg && ctrl_reg[CTRL_DUAL]) begin
            state_reg <= X_MON;
          end else if (step_done) begin
            state_reg <= X_MON;
          end
        end
        X_MON: begin
          if (step_done) begin
            if (ctrl_reg[CTRL_LOAD] &&
                !(smm_exit_reg && ctrl_reg[CTRL_DUAL])) begin
              state_reg <= X_LOAD;
            end else begin
              state_reg <= ST_RESUME;
            end
          end
        end
        X_LOAD: begin
          if (step_done) begin
            state_reg <= ST_RESUME;
          end
        end
        // Failure path never visits save or store states
        F_HOST: begin
          if (step_done) begin
            state_reg <= pdpte_need ? F_PDPTE : F_NMI;
          end
        end
        F_PDPTE: begin
          if (step_done) begin
            state_reg <= F_NMI;
          end
        end
        F_NMI:   state_reg <= F_LOAD;
        F_LOAD: begin
          if (step_done) begin
            state_reg <= ST_RESUME;
          end
        end
        ST_RESUME: begin
          if (step_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_HALT: state_reg <= ST_HALT;
        // Spare encoding falls back to idle
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Step requests decode straight from the state
  always_comb begin
    step_req               = '0;
    step_req.save_guest    = state_reg == X_SAVE;
    step_req.store_msr     = state_reg == X_STORE;
    step_req.load_host     = state_reg == F_HOST || (state_reg == X_HOST &&
                             !(smm_exit_reg && ctrl_reg[CTRL_DUAL]));
    step_req.reload_pdpte  = state_reg == F_PDPTE;
    step_req.clear_monitor = state_reg == X_MON;
    step_req.load_exit_msr = state_reg == X_LOAD || state_reg == F_LOAD;
    step_req.resume_host   = state_reg == ST_RESUME;
  end

  // Trace logging stays off for the whole exit or failure
  assign branch_log_off = !(state_reg == ST_IDLE || state_reg == ST_GUEST ||
                            state_reg == ST_ENTRY);

  // ----------------------------------------------------------------
  // Exit information and saved state
  // ----------------------------------------------------------------
  // Only cause and qualification change on a failure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= QUAL_ZERO;
      qual_reg  <= QUAL_ZERO;
    end else if (ce) begin
      if (mc_fail) begin
        cause_reg <= fail_cause(CAUSE_MCHK);
      end else if (guest_fail) begin
        cause_reg <= fail_cause(CAUSE_GUEST);
        qual_reg  <= guest_qual(ev.fail_kind);
      end else if (msr_fail) begin
        cause_reg <= fail_cause(CAUSE_MSR);
        qual_reg  <= ev.msr_index;
      end else if (state_reg == ST_GUEST && ev.exit_req) begin
        cause_reg <= {16'h0000, ev.exit_basic};
        qual_reg  <= QUAL_ZERO;
      end
    end
  end

  // Blocking captured at entry start, put back on a failure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_saved_reg <= 1'b0;
      nmi_block_out <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_IDLE && ev.entry_start) begin
        nmi_saved_reg <= ev.nmi_block;
      end
      if (state_reg == F_NMI) begin
        nmi_block_out <= nmi_saved_reg;
      end else begin
        nmi_block_out <= ev.nmi_block;
      end
    end
  end

  // Management-exit marker for the current exit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smm_exit_reg <= 1'b0;
    end else if (ce) begin
      if (smm_req) begin
        smm_exit_reg <= 1'b1;
      end else if (state_reg == ST_GUEST && ev.exit_req) begin
        smm_exit_reg <= 1'b0;
      end
    end
  end

  // Safer mode: set by its entry, cleared by its exit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safer_reg <= 1'b0;
    end else if (ce) begin
      if (ev.safer_enter) begin
        safer_reg <= 1'b1;
      end else if (ev.safer_leave) begin
        safer_reg <= 1'b0;
      end
    end
  end

  // Machine-check outcomes; shutdown flags hold until reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_reg   <= 1'b0;
      shut_reg <= 1'b0;
      txt_reg  <= 1'b0;
    end else if (ce) begin
      mc_reg <= mc_normal && ctrl_reg[CTRL_MCE];
      if (mc_normal && !ctrl_reg[CTRL_MCE]) begin
        txt_reg  <= safer_reg;
        shut_reg <= !safer_reg;
      end
    end
  end

  assign mc_deliver   = mc_reg;
  assign shutdown     = shut_reg;
  assign txt_shutdown = txt_reg;
  assign txt_code     = txt_reg ? TXT_MCHK_CODE : 16'h0000;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       aw_fire;
  logic       w_fire;
  logic       wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // Address and data taken in either order, one write in flight
  assign awready = ce && !aw_hold_reg && !bvalid_reg;
  assign wready  = ce && !w_hold_reg && !bvalid_reg;
  assign aw_fire = awvalid && awready;
  assign w_fire  = wvalid && wready;
  assign wr_go   = (aw_hold_reg || aw_fire) && (w_hold_reg || w_fire);
  assign wr_addr = aw_hold_reg ? aw_addr_reg : awaddr;
  assign wr_data = w_hold_reg ? w_data_reg : wdata;
  assign wr_strb = w_hold_reg ? w_strb_reg : wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_hold_reg <= 1'b1;
          aw_addr_reg <= awaddr;
        end
        if (w_fire) begin
          w_hold_reg <= 1'b1;
          w_data_reg <= wdata;
          w_strb_reg <= wstrb;
        end
        if (bvalid_reg && bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // Writable control; only the low byte holds fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ce && wr_go && wr_addr == CTRL_OFS && wr_strb[0]) begin
      ctrl_reg <= wr_data[CTRL_W-1:0];
    end
  end

  // Injection valid: an exit clears it, a failure leaves it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inject_reg <= 1'b0;
    end else if (ce) begin
      if (wr_go && wr_addr == INJECT_OFS && wr_strb[0]) begin
        inject_reg <= wr_data[0];
      end else if (state_reg == X_REC) begin
        inject_reg <= 1'b0;
      end
    end
  end

  // Read path, registered data, one read in flight
  assign arready = ce && !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (araddr)
          CTRL_OFS:   rdata_reg <= {25'h0000000, ctrl_reg};
          CAUSE_OFS:  rdata_reg <= cause_reg;
          QUAL_OFS:   rdata_reg <= qual_reg;
          STATUS_OFS: rdata_reg <= {txt_code, 8'h00, state_reg, txt_reg,
                                    shut_reg, safer_reg, nmi_saved_reg};
          INJECT_OFS: rdata_reg <= {31'h00000000, inject_reg};
          default:    rdata_reg <= 32'h0000_0000;
        endcase
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;

endmodule

//--- vm_exit_pkg.sv
/*
  Constants, register map and carrier types for the late entry-failure and
  exit sequencer. Assumes a core on the same clock that drives event pulses
  and acknowledges each sequencing step.
*/
// Function
// - Late entry failure writes basic cause into exit cause bits 15:0.
// - Guest-state check failure records basic cause 33.
// - Entry load-list register failure records basic cause 34.
// - Machine check taking the failure path records basic cause 41.
// - Entry failure sets cause bit 31 and clears bits 30:16.
// - Guest-state qualification is 0, 2, 3 or 4; value 1 unused.
// - Guest checks may run in any order; one cause reported.
// - Load-list failure qualification is one-based index of failing entry.
// - Other exit information fields stay unchanged on entry failure.
// - Host state loaded as on exit; page-dir entries reloaded when flagged.
// - Interrupt blocking restored to its state before the entry.
// - Final failure step loads registers from the exit load list.
// - Entry event-injection valid bit stays set on entry failure.
// - Failure writes no guest state and stores no exit-list registers.
// - Normal machine check with enable flag 1 delivers exception.
// - Enable flag 0: safer mode gives shutdown code 000C, else shutdown.
// - After guest state loaded, machine check takes failure path, cause 41.
// - Exit: record, save guest, store, load host, clear monitor, load list.
// - Dual-monitor management exits skip host load and exit-list load.
// - Exits are not logged in branch records or trace.
// - Management exit on system-management interrupt or root hypervisor call; a hypervisor call in guest also takes it here.
// - Safer mode lasts from its entry until its exit.
package vm_exit_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CAUSE_OFS  = 8'h04;
  localparam logic [7:0] QUAL_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] INJECT_OFS = 8'h10;

  // Control field positions
  localparam int CTRL_MCE   = 0;
  localparam int CTRL_PAE   = 1;
  localparam int CTRL_PG    = 2;
  localparam int CTRL_LMA   = 3;
  localparam int CTRL_STORE = 4;
  localparam int CTRL_LOAD  = 5;
  localparam int CTRL_DUAL  = 6;
  localparam int CTRL_W     = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Exit cause layout and basic causes
  localparam int          CAUSE_FAIL_BIT = 31;
  localparam logic [14:0] CAUSE_MID_ZERO = 15'h0000;
  localparam logic [15:0] CAUSE_GUEST    = 16'h0021;
  localparam logic [15:0] CAUSE_MSR      = 16'h0022;
  localparam logic [15:0] CAUSE_MCHK     = 16'h0029;

  // Guest failure kinds and their qualifications
  localparam logic [1:0]  KIND_OTHER = 2'h0;
  localparam logic [1:0]  KIND_PDPTE = 2'h1;
  localparam logic [1:0]  KIND_NMI   = 2'h2;
  localparam logic [1:0]  KIND_LINK  = 2'h3;
  localparam logic [31:0] QUAL_ZERO  = 32'h0000_0000;
  localparam logic [31:0] QUAL_PDPTE = 32'h0000_0002;
  localparam logic [31:0] QUAL_NMI   = 32'h0000_0003;
  localparam logic [31:0] QUAL_LINK  = 32'h0000_0004;

  // Trusted shutdown error code
  localparam logic [15:0] TXT_MCHK_CODE = 16'h000c;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ENTRY, ST_GUEST, X_REC, X_SAVE, X_STORE, X_HOST, X_MON,
    X_LOAD, F_HOST, F_PDPTE, F_NMI, F_LOAD, ST_RESUME, ST_HALT
  } seq_state_type;

  // Core events, all one-cycle pulses except levels noted
  typedef struct packed {
    logic        entry_start;   // Entry attempt begins
    logic        entry_ok;      // Entry finished, guest runs
    logic        guest_loaded;  // Level: guest state partly loaded
    logic        nmi_block;     // Level: current interrupt blocking
    logic        check_fail;    // Guest-state check failed
    logic [1:0]  fail_kind;     // Which check failed
    logic        msr_fail;      // Entry load-list load failed
    logic [31:0] msr_index;     // One-based failing entry
    logic        mchk;          // Machine check
    logic        exit_req;      // Ordinary exit event
    logic [15:0] exit_basic;    // Its basic cause
    logic        system_mgmt_interrupt;           // Management interrupt
    logic        hcall;         // Hypervisor call instruction
    logic        safer_enter;   // Safer mode entry instruction
    logic        safer_leave;   // Safer mode exit instruction
  } core_ev_type;

  // Steps requested of the core, level until step_done
  typedef struct packed {
    logic save_guest;
    logic store_msr;
    logic load_host;
    logic reload_pdpte;
    logic clear_monitor;
    logic load_exit_msr;
    logic resume_host;
  } step_type;

endpackage

//--- vm_exit_seq_properties.sv
/*
  Port assertions for the entry-failure sequencer.
  Assumes the bench holds ce high and binds this beside the design.
*/
module vm_exit_seq_properties (
  input wire logic                     aclk,          // Clock
  input wire logic                     aresetn,       // Reset, low
  input wire vm_exit_pkg::core_ev_type ev,            // Core events
  input wire logic                     step_done,     // Step finished
  input wire vm_exit_pkg::step_type    step_req,      // Step wanted
  input wire logic                     mc_deliver,    // Exception
  input wire logic                     shutdown,      // Shutdown
  input wire logic                     txt_shutdown,  // Trusted stop
  input wire logic [15:0]              txt_code,      // Stop code
  input wire logic                     branch_log_off // Trace off
);
  timeunit 1ns;
  timeprecision 1ps;
  import vm_exit_pkg::*;
  // ------------------------------------------------------------
  // Checks, all in the one core clock domain
  // ------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mc_deliver: assert property (mc_deliver
    |-> $past(ev.mchk) && !$past(mc_deliver))
    else $error("exception pulse without machine check");
  a_halt_cause: assert property ($rose(shutdown || txt_shutdown)
    |-> $past(ev.mchk && !ev.guest_loaded)) else $error("halt without early check");
  a_halt_hold: assert property ((shutdown || txt_shutdown)
    |=> $stable({shutdown, txt_shutdown})) else $error("halt state dropped");
  a_stop_code: assert property (txt_code ==
    (txt_shutdown ? TXT_MCHK_CODE : 16'h0000)) else $error("trusted stop code wrong");
  a_one_step: assert property ($onehot0(step_req)) else $error("two steps at once");
  a_step_hold: assert property (step_req != 0 && !step_done |=> $stable(step_req))
    else $error("step changed before done");
  a_trace_off: assert property (step_req != 0 |-> branch_log_off)
    else $error("trace not inhibited");
  a_resume_last: assert property (step_req.load_exit_msr && step_done
    |=> step_req.resume_host) else $error("no resume after list load");
  a_pdpte_order: assert property ($rose(step_req.reload_pdpte)
    |-> $past(step_req.load_host && step_done)) else $error("reload before host load");
  // Main scenarios reached
  cover property (mc_deliver);
  cover property ($rose(txt_shutdown));
  cover property (step_req.reload_pdpte);
endmodule

//--- core_model.sv
/*
  Core side that answers each requested step.
  Assumes one step at a time; replies alternate prompt and slow.
*/
module core_model (
  input  wire logic                  aclk,     // Core clock
  input  wire logic                  aresetn,  // Reset, low
  input  wire vm_exit_pkg::step_type step_req, // Step wanted
  output logic                       step_done // Step finished
);
  timeunit 1ns;
  timeprecision 1ps;
  import vm_exit_pkg::*;
  logic [1:0] cnt_reg;
  logic       slow_reg;
  // Slow replies hold the request to expose early step changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_done <= 1'h0;
      cnt_reg   <= 2'h0;
      slow_reg  <= 1'h0;
    end else begin
      step_done <= step_req != 0 && !step_done && cnt_reg == (slow_reg ? 2'h3 : 2'h0);
      cnt_reg   <= (step_done || step_req == 0) ? 2'h0 : cnt_reg + 2'h1;
      slow_reg  <= slow_reg ^ step_done;
    end
  end
endmodule

//--- testbench.sv
/*
  Self-checking bench for the sequencer.
  Assumes core_model answers steps; registers reached over AXI4-Lite.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vm_exit_pkg::*;
  logic        aclk = 0, aresetn = 0, step_done, mc_deliver, shutdown, txt_shutdown;
  logic        nmi_block_out, branch_log_off, awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, sh, sl, ss, sp, sm, sn;
  logic [15:0] txt_code;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  core_ev_type ev, lv, p;
  step_type    step_req;
  int          n_mismatch = 0, n_compared = 0;
  // ------------------------------------------------------------
  // Design, partner and clock
  // ------------------------------------------------------------
  vm_exit_seq uut (.aclk, .aresetn, .ce(1'h1), .ev, .step_done, .step_req, .nmi_block_out,
    .mc_deliver, .shutdown, .txt_shutdown, .txt_code, .branch_log_off, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'h1),
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'h1));
  core_model core (.aclk, .aresetn, .step_req, .step_done);
  initial forever #4 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus tasks start just after a rising edge and hold valid until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw;
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk); ha = awvalid && awready; hw = wvalid && wready;
      if (bvalid) begin chk(32'(bresp), 32'(er)); @(posedge aclk); return; end
      @(posedge aclk); if (ha) awvalid <= 1'h0; if (hw) wvalid <= 1'h0;
    end
    n_mismatch++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic h;
    araddr <= a; arvalid <= 1'h1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk); h = arvalid && arready;
      if (rvalid) begin chk(rdata, e); chk(32'(rresp), 32'(er)); @(posedge aclk); return; end
      @(posedge aclk); if (h) arvalid <= 1'h0;
    end
    n_mismatch++;
  endtask
  // One-cycle event, then watch steps until the sequence settles
  task automatic go(input core_ev_type e);
    ev <= e; @(posedge aclk); ev <= lv; {sh, sl, ss, sp, sm, sn} = 0;
    for (int i = 0; i < 200; i++) begin
      @(negedge aclk); sh |= step_req.load_host; sl |= step_req.load_exit_msr;
      ss |= step_req.save_guest | step_req.store_msr; sp |= step_req.reload_pdpte;
      sm |= mc_deliver; sn |= nmi_block_out & step_req.load_exit_msr;
      // Settled once idle, entering, in guest or halted, with no step asked
      if ((!branch_log_off || shutdown || txt_shutdown) && step_req == 0) begin
        @(posedge aclk); return;
      end
      @(posedge aclk);
    end
    n_mismatch++;
  endtask
  task automatic rst();
    aresetn <= 1'h0; repeat (8) @(posedge aclk); aresetn <= 1'h1; @(posedge aclk);
  endtask
  task automatic s_guest();
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_OFS, k[0] ? 32'h36 : 32'h3e, RESP_OKAY); wr(INJECT_OFS, 32'h1, RESP_OKAY);
      lv.nmi_block = 1; p = lv; p.entry_start = 1; go(p); lv.nmi_block = 0;
      p = lv; p.check_fail = 1; p.fail_kind = k[1:0]; go(p);
      rdc(CAUSE_OFS, 32'h8000_0021, RESP_OKAY);
      rdc(QUAL_OFS, k == 0 ? 32'h0 : 32'(k + 1), RESP_OKAY);
      chk({sn, sp, ss, sl, sh}, {27'h0, 1'h1, k[0], 3'h3});
      rdc(INJECT_OFS, 32'h1, RESP_OKAY);
    end
  endtask
  task automatic s_fail();
    p = lv; p.entry_start = 1; go(p); p = lv; p.msr_fail = 1; p.msr_index = 32'h7; go(p);
    rdc(CAUSE_OFS, 32'h8000_0022, RESP_OKAY);
    rdc(QUAL_OFS, 32'h7, RESP_OKAY);
    lv.guest_loaded = 1; p = lv; p.entry_start = 1; go(p); p = lv; p.mchk = 1; go(p);
    rdc(CAUSE_OFS, 32'h8000_0029, RESP_OKAY);
    rdc(QUAL_OFS, 32'h7, RESP_OKAY);
    lv.guest_loaded = 0;
  endtask
  task automatic s_mchk();
    wr(CTRL_OFS, 32'h1, RESP_OKAY); p = lv; p.entry_start = 1; go(p); p = lv; p.mchk = 1; go(p);
    chk(sm, 1'h1);
    rdc(CAUSE_OFS, 32'h8000_0029, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_OFS, 32'h0, RESP_OKAY); p = lv; p.safer_enter = 1; go(p);
      p = lv; p.safer_leave = k[0]; go(p); p = lv; p.entry_start = 1; go(p);
      p = lv; p.mchk = 1; go(p);
      chk({txt_shutdown, shutdown, txt_code},
          {!k[0], k[0], k[0] ? 16'h0 : 16'h000c});
      rst(); rdc(CTRL_OFS, 32'h0, RESP_OKAY);
    end
  endtask
  task automatic s_exit();
    wr(CTRL_OFS, 32'h70, RESP_OKAY); wr(INJECT_OFS, 32'h1, RESP_OKAY);
    p = lv; p.entry_start = 1; go(p); p = lv; p.entry_ok = 1; go(p);
    p = lv; p.exit_req = 1; p.exit_basic = 16'h0030; go(p);
    chk({ss, sl, sh}, 3'h7);
    rdc(CAUSE_OFS, 32'h30, RESP_OKAY);
    rdc(INJECT_OFS, 32'h0, RESP_OKAY);
    p = lv; p.system_mgmt_interrupt = 1; go(p); chk({sl, sh}, 2'h0);
    p = lv; p.hcall = 1; go(p); chk({sl, sh}, 2'h0);
    wr(8'h40, 32'h1, RESP_SLVERR); rdc(8'h40, 32'h0, RESP_SLVERR);
  endtask
  // Main sequence and watchdog
  initial begin
    {ev, lv, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    rst(); s_guest(); s_fail(); s_mchk(); s_exit(); final_report();
  end
  initial begin
    repeat (20000) @(posedge aclk); n_mismatch++; final_report();
  end
endmodule
bind vm_exit_seq vm_exit_seq_properties props (.aclk, .aresetn, .ev, .step_done, .step_req,
  .mc_deliver, .shutdown, .txt_shutdown, .txt_code, .branch_log_off);
